// [hw/mdl_msg_doorbell.sv]
// message and doorbell logical layer with payload fifo
// Behaviour
// - doorbell carries 16-bit info, never a payload.
// - received doorbells are stored in a hardware queue for the processor.
// - each queue entry keeps sender identity with the info value.
// - a message has at most 16 segments, each answered by a response.
// - message payloads are whole doublewords, never empty.
// - segments accepted in any order using length and index fields.
// - separate reassembly state kept per mailbox and slot.
// - every non-final segment carries exactly the standard size.
// - write address derived from mailbox, slot, index and size.
// - writes may snoop caches when the mailbox is cacheable.
// - payloads big-endian, byte-swapped for little-endian memory.
// - short quantities sit in their address lanes of the doubleword.
// - type 0 implementation-defined, 1-9 reserved, 10 doorbell, 11 message.
// - never emit a reserved format type.
// - reserved fields sent as zero, ignored on receipt.
// - reserved encodings in needed fields answered with error.
// - unrecognised implementation-defined packets are ignored.
// - packet stream starts with the 4-bit format type.
// - doorbell stream is type, 8 reserved, tag, info msb, info lsb.
// - retry when mailbox or doorbell queue is busy.
// - length field holds segment count minus one.
// - size codes 9 to 14 select 8 to 256 bytes, rest reserved.
`timescale 1ns/10ps
`include "mdl_defs.svh"

module mdl_fifo #(
  parameter int WIDTH = `MDL_DATA_WIDTH,
  parameter int DEPTH = `MDL_FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             ready_q;
  logic             push;
  logic             pop;

  // handshakes; ready is a flop so the source sees honest back-pressure
  assign push      = in_valid && ready_q;
  assign pop       = out_valid && out_ready;
  assign in_ready  = ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign cnt_d     = cnt_q + CW'(push) - CW'(pop);

  // storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clock) begin
    if (reset) begin
      // ready held low in reset so no word slips in before the pointers settle
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != CW'(DEPTH));
    end
  end
endmodule

module mdl_msg_doorbell (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        rx_hdr_valid,
  output logic             rx_hdr_ready,
  input  wire logic [3:0]  rx_ftype,
  input  wire logic [7:0]  rx_source_id,
  input  wire logic [7:0]  rx_source_transaction_tag,
  input  wire logic [15:0] rx_info,
  input  wire logic [3:0]  rx_msg_length,
  input  wire logic [3:0]  rx_msg_segment,
  input  wire logic [1:0]  rx_mailbox,
  input  wire logic [1:0]  rx_letter,
  input  wire logic [3:0]  rx_std_size,
  input  wire logic [5:0]  rx_dwords,
  input  wire logic        rx_data_valid,
  output logic             rx_data_ready,
  input  wire logic [63:0] rx_data,
  input  wire logic [31:0] mailbox_base,
  input  wire logic [3:0]  mailbox_busy,
  input  wire logic [3:0]  mailbox_cacheable,
  input  wire logic        mem_little_endian,
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  output logic      [31:0] mem_wr_addr,
  output logic      [63:0] mem_wr_data,
  output logic             mem_wr_snoop,
  output logic             msg_done,
  output logic      [3:0]  msg_done_slot,
  output logic             db_valid,
  input  wire logic        db_pop,
  output logic      [7:0]  db_source_id,
  output logic      [15:0] db_info,
  output logic             resp_valid,
  input  wire logic        resp_ready,
  output logic      [1:0]  resp_status,
  output logic      [7:0]  resp_dest_id,
  output logic      [7:0]  resp_source_transaction_tag,
  input  wire logic        tx_db_valid,
  output logic             tx_db_ready,
  input  wire logic [7:0]  tx_db_tag,
  input  wire logic [15:0] tx_db_info,
  output logic             tx_frame_valid,
  input  wire logic        tx_frame_ready,
  output logic      [35:0] tx_frame_bits
);

  // byte lanes reversed for little-endian memory
  function automatic logic [63:0] mdl_bswap(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[8*i +: 8] = d[8*(7-i) +: 8];
    end
    return r;
  endfunction

  // segments that complete a message of the given length
  function automatic logic [15:0] mdl_len_mask(input logic [3:0] len);
    logic [16:0] m;
    m = (17'h0_0002 << len) - 17'h0_0001;
    return m[15:0];
  endfunction

  mdl_pkg::mdl_state_t state_q;
  mdl_pkg::mdl_state_t state_d;

  logic        hdr_ready_q;
  logic        accept;
  logic [63:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  logic        room;

  logic [7:0]  tag_q;
  logic [7:0]  src_q;
  logic [1:0]  status_q;
  logic        write_q;
  logic        respond_q;
  logic [5:0]  left_q;
  logic [31:0] addr_q;
  logic [3:0]  slot_q;
  logic [3:0]  seg_q;
  logic [3:0]  len_q;

  logic [15:0] seen_q [16];
  logic [3:0]  slen_q [16];
  logic [23:0] dbq_q  [`MDL_DB_DEPTH];
  logic [2:0]  db_wr_q;
  logic [2:0]  db_rd_q;
  logic [3:0]  db_cnt_q;

  logic [3:0]  slot;
  logic [5:0]  size_dw;
  logic [11:0] seg_off;
  logic        is_db;
  logic        is_msg;
  logic        ftype_rsv;
  logic        ssize_bad;
  logic        msg_bad;
  logic        db_full;
  logic        do_err;
  logic        do_retry;
  logic        db_push;
  logic        db_take;
  logic [15:0] seen_new;

  // payload fifo; its ready stalls the payload source
  mdl_fifo #(
    .WIDTH (`MDL_DATA_WIDTH),
    .DEPTH (`MDL_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (rx_data_valid),
    .in_ready  (rx_data_ready),
    .in_data   (rx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // header decode and checks at acceptance
  assign accept    = rx_hdr_valid && hdr_ready_q;
  assign slot      = {rx_mailbox, rx_letter};
  assign is_db     = (rx_ftype == `MDL_FTYPE_DOORBELL);
  assign is_msg    = (rx_ftype == `MDL_FTYPE_MESSAGE);
  assign ftype_rsv = (rx_ftype != `MDL_FTYPE_IMPL) && (rx_ftype <= `MDL_FTYPE_RSV_LAST);
  assign ssize_bad = (rx_std_size < `MDL_SSIZE_MIN) || (rx_std_size > `MDL_SSIZE_MAX);
  assign size_dw   = `MDL_SSIZE_MIN_DW << (rx_std_size - `MDL_SSIZE_MIN);
  assign seg_off   = 12'(rx_msg_segment) * (`MDL_SSIZE_MIN_BYTES << (rx_std_size - `MDL_SSIZE_MIN));
  assign db_full   = (db_cnt_q == 4'(`MDL_DB_DEPTH));

  // a mismatched length against a live slot is a corrupt message
  assign msg_bad = ssize_bad
    || (rx_dwords == 6'h00)
    || (rx_msg_segment > rx_msg_length)
    || ((rx_msg_segment != rx_msg_length) && (rx_dwords != size_dw))
    || ((rx_msg_segment == rx_msg_length) && (rx_dwords > size_dw))
    || ((seen_q[slot] != 16'h0000) && (slen_q[slot] != rx_msg_length));

  // error outranks retry so bad packets are never resent forever
  assign do_err   = ftype_rsv || (is_msg && msg_bad) || (is_db && rx_dwords != 6'h00);
  assign do_retry = (is_msg && mailbox_busy[rx_mailbox]) || (is_db && db_full);
  assign db_push  = accept && is_db && !do_err && !do_retry;

  // payload words leave the fifo when the write register can take them; dropped words leave at once
  assign room     = !mem_wr_valid || mem_wr_ready;
  assign fifo_pop = (state_q == mdl_pkg::MDL_MOVE) && fifo_valid && (!write_q || room);

  // receive sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      mdl_pkg::MDL_IDLE: begin
        if (accept) begin
          state_d = (rx_dwords == 6'h00) ? mdl_pkg::MDL_FLUSH : mdl_pkg::MDL_MOVE;
        end
      end
      mdl_pkg::MDL_MOVE: begin
        if (fifo_pop && left_q == 6'h01) begin
          state_d = mdl_pkg::MDL_FLUSH;
        end
      end
      mdl_pkg::MDL_FLUSH: begin
        // answer only once the last word has left for memory
        if (!mem_wr_valid) begin
          state_d = respond_q ? mdl_pkg::MDL_RESP : mdl_pkg::MDL_IDLE;
        end
      end
      mdl_pkg::MDL_RESP: begin
        if (resp_ready) begin
          state_d = mdl_pkg::MDL_IDLE;
        end
      end
      default: state_d = mdl_pkg::MDL_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q     <= mdl_pkg::MDL_IDLE;
      hdr_ready_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      hdr_ready_q <= (state_d == mdl_pkg::MDL_IDLE);
    end
  end

  // request context latched on acceptance
  always_ff @(posedge clock) begin
    if (reset) begin
      tag_q     <= 8'h00;
      src_q     <= 8'h00;
      status_q  <= mdl_pkg::MDL_DONE;
      write_q   <= 1'b0;
      respond_q <= 1'b0;
      left_q    <= 6'h00;
      addr_q    <= 32'h0000_0000;
      slot_q    <= 4'h0;
      seg_q     <= 4'h0;
      len_q     <= 4'h0;
    end else if (accept) begin
      tag_q     <= rx_source_transaction_tag;
      src_q     <= rx_source_id;
      status_q  <= do_err ? mdl_pkg::MDL_ERROR :
                   do_retry ? mdl_pkg::MDL_RETRY : mdl_pkg::MDL_DONE;
      write_q   <= is_msg && !do_err && !do_retry;
      respond_q <= is_db || is_msg || ftype_rsv;
      left_q    <= rx_dwords;
      addr_q    <= mailbox_base + {16'h0000, slot, 12'h000} + {20'h0_0000, seg_off};
      slot_q    <= slot;
      seg_q     <= rx_msg_segment;
      len_q     <= rx_msg_length;
    end else if (fifo_pop) begin
      left_q <= left_q - 6'h01;
      addr_q <= addr_q + `MDL_DW_BYTES;
    end
  end

  // memory write register; dropped payloads never reach it
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_wr_valid <= 1'b0;
      mem_wr_addr  <= 32'h0000_0000;
      mem_wr_data  <= 64'h0000_0000_0000_0000;
      mem_wr_snoop <= 1'b0;
    end else if (fifo_pop && write_q) begin
      mem_wr_valid <= 1'b1;
      mem_wr_addr  <= addr_q;
      mem_wr_data  <= mem_little_endian ? mdl_bswap(fifo_data) : fifo_data;
      mem_wr_snoop <= mailbox_cacheable[slot_q[3:2]];
    end else if (mem_wr_ready) begin
      mem_wr_valid <= 1'b0;
    end
  end

  // per-slot reassembly; completion when every index up to length is seen
  assign seen_new = seen_q[slot_q] | (16'h0001 << seg_q);

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        seen_q[i] <= 16'h0000;
        slen_q[i] <= 4'h0;
      end
      msg_done      <= 1'b0;
      msg_done_slot <= 4'h0;
    end else begin
      msg_done <= 1'b0;
      if (state_q == mdl_pkg::MDL_FLUSH && !mem_wr_valid && write_q) begin
        slen_q[slot_q] <= len_q;
        if (seen_new == mdl_len_mask(len_q)) begin
          seen_q[slot_q] <= 16'h0000;
          msg_done       <= 1'b1;
          msg_done_slot  <= slot_q;
        end else begin
          seen_q[slot_q] <= seen_new;
        end
      end
    end
  end

  // response register, held until taken
  always_ff @(posedge clock) begin
    if (reset) begin
      resp_valid                  <= 1'b0;
      resp_status                 <= mdl_pkg::MDL_DONE;
      resp_dest_id                <= 8'h00;
      resp_source_transaction_tag <= 8'h00;
    end else if (state_d == mdl_pkg::MDL_RESP && state_q != mdl_pkg::MDL_RESP) begin
      resp_valid                  <= 1'b1;
      resp_status                 <= status_q;
      resp_dest_id                <= src_q;
      resp_source_transaction_tag <= tag_q;
    end else if (resp_ready) begin
      resp_valid <= 1'b0;
    end
  end

  // doorbell queue; the head lags one cycle, so pops are two cycles apart
  assign db_take = db_pop && db_valid;

  always_ff @(posedge clock) begin
    if (db_push) begin
      dbq_q[db_wr_q] <= {rx_source_id, rx_info};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      db_wr_q      <= 3'h0;
      db_rd_q      <= 3'h0;
      db_cnt_q     <= 4'h0;
      db_valid     <= 1'b0;
      db_source_id <= 8'h00;
      db_info      <= 16'h0000;
    end else begin
      db_wr_q      <= db_wr_q + 3'(db_push);
      db_rd_q      <= db_rd_q + 3'(db_take);
      db_cnt_q     <= db_cnt_q + 4'(db_push) - 4'(db_take);
      db_valid     <= (db_cnt_q != 4'h0) && !db_take;
      db_source_id <= dbq_q[db_rd_q][23:16];
      db_info      <= dbq_q[db_rd_q][15:0];
    end
  end

  // outgoing doorbell frame, single slot
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_frame_valid <= 1'b0;
      tx_frame_bits  <= 36'h0_0000_0000;
      tx_db_ready    <= 1'b0;
    end else if (tx_db_valid && tx_db_ready) begin
      tx_frame_valid <= 1'b1;
      // only the doorbell type is ever built here
      tx_frame_bits  <= {`MDL_FTYPE_DOORBELL, `MDL_RSRV_ZERO, tx_db_tag, tx_db_info};
      tx_db_ready    <= 1'b0;
    end else if (tx_frame_valid && tx_frame_ready) begin
      tx_frame_valid <= 1'b0;
      tx_db_ready    <= 1'b1;
    end else begin
      tx_db_ready    <= !tx_frame_valid;
    end
  end

  assign rx_hdr_ready = hdr_ready_q;
endmodule

// [hw/mdl_defs.svh]
// constants for the message and doorbell logical layer
`ifndef MDL_DEFS_SVH
`define MDL_DEFS_SVH

// format types
`define MDL_FTYPE_IMPL      4'h0
`define MDL_FTYPE_RSV_LAST  4'h9
`define MDL_FTYPE_DOORBELL  4'hA
`define MDL_FTYPE_MESSAGE   4'hB

// standard-size codes, smallest code is 8 bytes
`define MDL_SSIZE_MIN       4'h9
`define MDL_SSIZE_MAX       4'hE
`define MDL_SSIZE_MIN_BYTES 12'h008
`define MDL_SSIZE_MIN_DW    6'h01

// doubleword and slot layout
`define MDL_DW_BYTES        32'h0000_0008
`define MDL_SLOT_SHIFT      12
`define MDL_RSRV_ZERO       8'h00

// queue depths
`define MDL_DB_DEPTH        8
`define MDL_FIFO_DEPTH      8
`define MDL_DATA_WIDTH      64

`endif

// [hw/mdl_pkg.sv]
// types for the message and doorbell logical layer
package mdl_pkg;

  // receive flow, gray coded along idle-move-flush-respond
  typedef enum logic [1:0] {
    MDL_IDLE  = 2'b00,
    MDL_MOVE  = 2'b01,
    MDL_FLUSH = 2'b11,
    MDL_RESP  = 2'b10
  } mdl_state_t;

  // response status
  typedef enum logic [1:0] {
    MDL_DONE  = 2'b00,
    MDL_RETRY = 2'b01,
    MDL_ERROR = 2'b10
  } mdl_status_t;

endpackage

// [verif/mdl_asserts.sv]
// port checker for the message and doorbell layer
`timescale 1ns/10ps
module mdl_asserts (
  input logic        clock,
  input logic        reset,
  input logic        rx_hdr_valid,
  input logic        rx_hdr_ready,
  input logic [3:0]  rx_ftype,
  input logic [15:0] rx_info,
  input logic [3:0]  rx_msg_length,
  input logic [3:0]  rx_msg_segment,
  input logic [1:0]  rx_mailbox,
  input logic [3:0]  rx_std_size,
  input logic [5:0]  rx_dwords,
  input logic [3:0]  mailbox_busy,
  input logic        mem_wr_valid,
  input logic        mem_wr_ready,
  input logic [31:0] mem_wr_addr,
  input logic        db_valid,
  input logic        db_pop,
  input logic [15:0] db_info,
  input logic        resp_valid,
  input logic        resp_ready,
  input logic [1:0]  resp_status,
  input logic [7:0]  resp_source_transaction_tag,
  input logic        tx_db_valid,
  input logic        tx_db_ready,
  input logic [7:0]  tx_db_tag,
  input logic [15:0] tx_db_info,
  input logic        tx_frame_valid,
  input logic        tx_frame_ready,
  input logic [35:0] tx_frame_bits
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire hdr_acc = rx_hdr_valid && rx_hdr_ready;
  // header steps; busy case uses an otherwise legal one-word request
  sequence s_rsv_hdr;
    hdr_acc && rx_ftype inside {[4'h1:4'h9]};
  endsequence
  sequence s_busy_msg;
    hdr_acc && rx_ftype == 4'hB && mailbox_busy[rx_mailbox] && rx_std_size == 4'h9
      && rx_dwords == 6'h01 && rx_msg_length == 4'h0 && rx_msg_segment == 4'h0;
  endsequence
  sequence s_db_new;
    hdr_acc && rx_ftype == 4'hA && rx_dwords == 6'h00 && !db_valid && !db_pop;
  endsequence
  chk_rsv_error: assert property (s_rsv_hdr |-> ##[2:60] resp_valid && resp_status == 2'h2)
    else $error("reserved format type not refused");
  chk_busy_retry: assert property (
    s_busy_msg |-> ##[2:60] resp_valid && resp_status == 2'h1)
    else $error("busy mailbox not answered with retry");
  chk_db_queue: assert property (s_db_new |-> ##2 db_valid && db_info == $past(rx_info, 2))
    else $error("doorbell not queued");
  chk_frame_head: assert property (tx_frame_valid |-> tx_frame_bits[35:24] == 12'hA00)
    else $error("frame type or reserved bits wrong");
  chk_frame_load: assert property (
    tx_db_valid && tx_db_ready |=> tx_frame_valid
      && tx_frame_bits[23:0] == {$past(tx_db_tag), $past(tx_db_info)})
    else $error("frame does not carry tag and info");
  chk_frame_hold: assert property (
    tx_frame_valid && !tx_frame_ready |=> tx_frame_valid && $stable(tx_frame_bits))
    else $error("frame changed before taken");
  chk_resp_hold: assert property (
    resp_valid && !resp_ready |=> resp_valid
      && $stable({resp_status, resp_source_transaction_tag}))
    else $error("response changed before taken");
  chk_wr_hold: assert property (
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr))
    else $error("write address changed before taken");
endmodule

bind mdl_msg_doorbell mdl_asserts chk_u (.*);

// [verif/mdl_peer.sv]
// far side: remote element taking doorbell frames and responses
`timescale 1ns/10ps
module mdl_peer (
  input  logic clock,
  input  logic reset,
  input  logic tx_frame_valid,
  input  logic resp_valid,
  output logic tx_frame_ready = 1'b0,
  output logic resp_ready = 1'b0
);
  // random stalls so the block must hold what it offers
  always @(posedge clock) begin
    tx_frame_ready <= !reset && tx_frame_valid && 1'($urandom_range(0, 1));
    resp_ready     <= !reset && resp_valid && 1'($urandom_range(0, 1));
  end
endmodule

// [verif/mdl_msg_doorbell_tb.sv]
// self-checking bench for the message and doorbell layer
`timescale 1ns/10ps
module mdl_msg_doorbell_tb;
  logic         clock = 1'b0, reset = 1'b1, rx_hdr_valid = 1'b0, rx_data_valid = 1'b0;
  logic         mem_little_endian = 1'b0, mem_wr_ready = 1'b0, db_pop = 1'b0;
  logic         tx_db_valid = 1'b0, rx_hdr_ready, rx_data_ready, mem_wr_valid, mem_wr_snoop;
  logic         msg_done, db_valid, resp_valid, resp_ready, tx_db_ready, tx_frame_valid;
  logic         tx_frame_ready;
  logic [1:0]   rx_mailbox = 2'h0, rx_letter = 2'h0, resp_status;
  logic [3:0]   rx_ftype = 4'h0, rx_msg_length = 4'h0, rx_msg_segment = 4'h0;
  logic [3:0]   rx_std_size = 4'h0, mailbox_busy = 4'h0, mailbox_cacheable = 4'h0;
  logic [3:0]   msg_done_slot;
  logic [5:0]   rx_dwords = 6'h00;
  logic [7:0]   rx_source_id = 8'h00, rx_source_transaction_tag = 8'h00, tx_db_tag = 8'h00;
  logic [7:0]   db_source_id, resp_dest_id, resp_source_transaction_tag, sid, tag = 8'h00;
  logic [15:0]  rx_info = 16'h0000, tx_db_info = 16'h0000, db_info, inf;
  logic [31:0]  mailbox_base = 32'h0000_0000, mem_wr_addr;
  logic [35:0]  tx_frame_bits;
  logic [63:0]  rx_data = 64'h0, mem_wr_data;
  logic [127:0] rq[$], wq[$], fq[$], dq[$], bq[$];
  int           err_count = 0, comparisons = 0, cycles = 0;

  mdl_msg_doorbell dut_u (.*);
  mdl_peer peer_u (.*);

  always #2.5 clock = ~clock;

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // an empty queue gives unknown, which never matches
  function automatic logic [127:0] pop(ref logic [127:0] q[$]);
    if (q.size() == 0)
      return 'x;
    return q.pop_front();
  endfunction

  // cycle ceiling, far above a clean run; a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles > 6000) begin
      err_count++;
      summarize();
    end
  end

  // results leave the block; each meets the oldest note of its kind
  always @(posedge clock) begin
    mem_wr_ready <= 1'($urandom_range(0, 1));
    if (resp_valid && resp_ready)
      chk({resp_status, resp_source_transaction_tag, resp_dest_id}, pop(rq));
    if (mem_wr_valid && mem_wr_ready)
      chk({mem_wr_snoop, mem_wr_addr, mem_wr_data}, pop(wq));
    if (tx_frame_valid && tx_frame_ready)
      chk(tx_frame_bits, pop(fq));
    if (msg_done)
      chk(msg_done_slot, pop(dq));
  end

  // one header; fresh tag each time, so none is reused early
  task automatic hdr(input logic [3:0] f, input logic [5:0] dw, input logic [1:0] st);
    tag = tag + 8'h01;
    sid = 8'($urandom);
    inf = 16'($urandom);
    if (f != 4'h0)
      rq.push_back({st, tag, sid});
    rx_ftype <= f;
    rx_dwords <= dw;
    rx_source_id <= sid;
    rx_source_transaction_tag <= tag;
    rx_info <= inf;
    rx_hdr_valid <= 1'b1;
    do @(posedge clock); while (!rx_hdr_ready);
    rx_hdr_valid <= 1'b0;
    @(posedge clock);
  endtask

  // payload words ahead of the header; fifo holds at most 8
  task automatic msg(input logic [3:0] f, mb, lt, ln, sg, c, input logic [5:0] dw,
                     input logic [1:0] st);
    logic [63:0] d, e;
    rx_mailbox <= mb[1:0];
    rx_letter <= lt[1:0];
    rx_msg_length <= ln;
    rx_msg_segment <= sg;
    rx_std_size <= c;
    for (int k = 0; k < dw; k++) begin
      d = {$urandom, $urandom};
      e = d;
      if (mem_little_endian)
        e = {<<8{d}};
      if (st == 2'h0)
        wq.push_back({mailbox_cacheable[mb], mailbox_base + 32'({mb[1:0], lt[1:0]}) * 32'h1000
          + 32'(sg) * (32'h8 << (c - 4'h9)) + 32'(k) * 32'h8, e});
      rx_data <= d;
      rx_data_valid <= 1'b1;
      do @(posedge clock); while (!rx_data_ready);
    end
    rx_data_valid <= 1'b0;
    rx_data <= ~rx_data;
    hdr(f, dw, st);
  endtask

  task automatic drain;
    for (int i = 0; i < 300 && rq.size() + wq.size() + dq.size() + fq.size() > 0; i++)
      @(posedge clock);
    chk(rq.size() + wq.size() + dq.size() + fq.size(), 0);
  endtask

  // main sequence
  initial begin
    void'($urandom(16));
    mailbox_base <= $urandom & 32'hFFFF_0000;
    mailbox_cacheable <= 4'h4;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // outgoing doorbells
    repeat (4) begin
      tag = tag + 8'h01;
      inf = 16'($urandom);
      fq.push_back({4'hA, 8'h00, tag, inf});
      tx_db_tag <= tag;
      tx_db_info <= inf;
      tx_db_valid <= 1'b1;
      do @(posedge clock); while (!tx_db_ready);
      tx_db_valid <= 1'b0;
      @(posedge clock);
    end
    // incoming doorbell queued, read at the head, then popped
    hdr(4'hA, 6'h00, 2'h0);
    for (int i = 0; i < 20 && db_valid !== 1'b1; i++)
      @(posedge clock);
    chk({db_source_id, db_info}, {sid, inf});
    db_pop <= 1'b1;
    @(posedge clock);
    db_pop <= 1'b0;
    // eight doorbells fill the queue, a ninth is retried, then all read back in order
    repeat (8) begin
      hdr(4'hA, 6'h00, 2'h0);
      bq.push_back({sid, inf});
    end
    hdr(4'hA, 6'h00, 2'h1);
    repeat (8) begin
      // head shows a cycle after the pop lands, so pops stay two apart
      @(posedge clock);
      for (int i = 0; i < 20 && db_valid !== 1'b1; i++)
        @(posedge clock);
      chk({db_source_id, db_info}, pop(bq));
      db_pop <= 1'b1;
      @(posedge clock);
      db_pop <= 1'b0;
    end
    msg(4'hA, 4'h0, 4'h0, 4'h0, 4'h0, 4'h9, 6'h01, 2'h2);
    for (int t = 0; t < 10; t++)
      hdr(4'(t), 6'h00, 2'h2);
    // refused message fields
    msg(4'hB, 4'h1, 4'h0, 4'h0, 4'h0, 4'hF, 6'h01, 2'h2);
    msg(4'hB, 4'h1, 4'h0, 4'h0, 4'h1, 4'h9, 6'h01, 2'h2);
    msg(4'hB, 4'h1, 4'h0, 4'h2, 4'h0, 4'hA, 6'h01, 2'h2);
    msg(4'hB, 4'h1, 4'h0, 4'h0, 4'h0, 4'h9, 6'h00, 2'h2);
    drain();
    // two slots of one mailbox in flight, segments out of order
    mem_little_endian <= 1'b1;
    @(posedge clock);
    msg(4'hB, 4'h2, 4'h0, 4'h1, 4'h0, 4'hA, 6'h02, 2'h0);
    msg(4'hB, 4'h2, 4'h1, 4'h1, 4'h1, 4'hB, 6'h02, 2'h0);
    dq.push_back(4'h9);
    dq.push_back(4'h8);
    msg(4'hB, 4'h2, 4'h1, 4'h1, 4'h0, 4'hB, 6'h04, 2'h0);
    msg(4'hB, 4'h2, 4'h0, 4'h1, 4'h1, 4'hA, 6'h01, 2'h0);
    drain();
    // busy mailbox retried, then resent
    mem_little_endian <= 1'b0;
    mailbox_busy <= 4'h4;
    msg(4'hB, 4'h2, 4'h3, 4'h0, 4'h0, 4'h9, 6'h01, 2'h1);
    mailbox_busy <= 4'h0;
    dq.push_back(4'hB);
    msg(4'hB, 4'h2, 4'h3, 4'h0, 4'h0, 4'h9, 6'h01, 2'h0);
    // every legal size code, 9 to 14, at segment 1
    for (int c = 9; c < 15; c++)
      msg(4'hB, 4'h3, 4'(c % 4), 4'h1, 4'h1, 4'(c), 6'h01, 2'h0);
    drain();
    // fill the fifo until it refuses, then let the header drain it
    dq.push_back(4'h0);
    msg(4'hB, 4'h0, 4'h0, 4'h0, 4'h0, 4'hC, 6'h08, 2'h0);
    drain();
    summarize();
  end
endmodule
